// ### include/dvf_pkg.sv
package dvf_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_VERIFY       = 8'h40;
  localparam logic [7:0] CMD_VERIFY_EXT   = 8'h42;
  localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3C;
  localparam logic [7:0] CMD_FORMAT       = 8'h50;

  // ----------------------------------------------------------------
  // Widths and sector geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WIDX_W = 8;
  localparam int unsigned WORDS  = 256;
  localparam int unsigned CNT_W  = 17;
  localparam int unsigned ADDR_W = 48;
  localparam int unsigned ENT_W  = 9;
  localparam int unsigned CYL_W  = 16;
  localparam int unsigned HEAD_W = 4;
  localparam int unsigned SECT_W = 8;
  localparam int unsigned CHS_PAD_W = ADDR_W - CYL_W - HEAD_W - SECT_W;

  typedef logic [CNT_W-1:0]  dvf_cnt_t;
  typedef logic [WIDX_W-1:0] dvf_widx_t;

  localparam dvf_widx_t LAST_WORD  = 8'hFF;
  localparam dvf_cnt_t  CNT28_ZERO = 17'h00100;
  localparam dvf_cnt_t  CNT48_ZERO = 17'h10000;
  localparam dvf_cnt_t  CNT_ONE    = 17'h00001;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_SEEK = 2'h1, ST_MEDIA = 2'h2, ST_XFER = 2'h3} dvf_st_e;
  typedef enum logic [1:0] {MOP_READ = 2'h0, MOP_WRITE = 2'h1, MOP_FORMAT = 2'h2} dvf_mop_e;
  typedef enum logic [1:0] {ERR_NONE = 2'h0, ERR_ABORT = 2'h1, ERR_MEDIA = 2'h2} dvf_err_e;

  // ----------------------------------------------------------------
  // State records and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    dvf_st_e                st;
    dvf_mop_e               op;
    dvf_err_e               err;
    logic                   bsy;
    logic                   drq;
    logic                   irq;
    logic                   seeking;
    logic                   seek_req;
    logic                   media_start;
    dvf_cnt_t               cnt;
    logic [ADDR_W-1:0]      addr;
    dvf_widx_t              widx;
  } dvf_core_s;

  typedef struct packed {
    logic [WORDS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]            rd_data;
  } dvf_buf_s;

  typedef struct packed {
    logic             done;
    logic [ENT_W-1:0] count;
  } dvf_parse_s;

  localparam dvf_core_s  CORE_RST  = '0;
  localparam dvf_buf_s   BUF_RST   = '0;
  localparam dvf_parse_s PARSE_RST = '0;

endpackage

// ### include/dvf_buf_if.sv
interface dvf_buf_if;
  logic                         wr_en;
  logic [dvf_pkg::WIDX_W-1:0]   wr_addr;
  logic [dvf_pkg::DATA_W-1:0]   wr_data;
  logic [dvf_pkg::WIDX_W-1:0]   rd_addr;
  logic [dvf_pkg::DATA_W-1:0]   rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport mon (input wr_en, input wr_addr, input wr_data);
endinterface

// ### core/dvf_sector_buf.sv
module dvf_sector_buf (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Buffer port
  dvf_buf_if.mem    bus
);

  dvf_pkg::dvf_buf_s r, n;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Read is registered; a same-cycle write shows on the next read
  always_comb begin
    n = r;
    if (bus.wr_en) begin
      n.mem[bus.wr_addr] = bus.wr_data;
    end
    n.rd_data = r.mem[bus.rd_addr];
  end

  // State register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= dvf_pkg::BUF_RST;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign bus.rd_data = r.rd_data;

endmodule // dvf_sector_buf

// ### core/dvf_fmt_parser.sv
module dvf_fmt_parser (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // Control
  input  wire logic                       clear_i,
  // Watched buffer writes
  dvf_buf_if.mon                          bus,
  // Result
  output logic [dvf_pkg::ENT_W-1:0]       entries_o
);

  dvf_pkg::dvf_parse_s r, n;

  // ----------------------------------------------------------------
  // Table walk
  // ----------------------------------------------------------------
  // One word per sector; type byte never matters, so only a zero word ends it
  always_comb begin
    n = r;
    if (clear_i) begin
      n = dvf_pkg::PARSE_RST;
    end else if (bus.wr_en && !r.done) begin
      if (bus.wr_data == '0) begin
        n.done = 1'b1;  // Rest of the block is ignored
      end else begin
        n.count = r.count + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= dvf_pkg::PARSE_RST;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign entries_o = r.count;

endmodule // dvf_fmt_parser

// ### core/dvf_core.sv
// Overview of operation
// - 28-bit verify reads media like a read, never raises DRQ, returns no data.
// - Each verify command gives exactly one interrupt, at completion or on error.
// - Code 42h is the 48-bit verify, reading media without DRQ or data.
// - 48-bit verify is accepted only in LBA mode, else aborted.
// - Command 3Ch behaves as plain sector write, with no read-back check.
// - Write-with-verify takes 1-256 sectors from sector count, then writes media.
// - Host loads start address in CHS or LBA; writing starts there.
// - Write-with-verify holds DRQ for one sector, then drops DRQ, raises BSY.
// - Before each further sector: DRQ set, BSY cleared, interrupt raised.
// - Off-track head seeks on its own before writing the buffered sector.
// - After the last buffered sector is written, BSY clears and an interrupt issued.
// - Track format 50h is aborted whenever LBA mode is selected.
// - Format writes the CHS-selected track per the host's buffered table.
// - Format raises DRQ at once and fills buffer until table arrives.
// - After 512 format bytes, DRQ clears, BSY sets, format starts.
// - Before formatting, an off-track head seeks to the target on its own.
// - Format completion clears BSY and raises an interrupt.
// - Table holds one 16-bit entry per sector: sector number high, type low.
// - Only type 00h is done; any type is accepted with the same result.
// - Interleave is always one; bytes after the table are ignored.
module dvf_core (
  // Clock, reset, enable
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Task file and command strobe
  input  wire logic                        cmd_wr_i,
  input  wire logic [7:0]                  cmd_code_i,
  input  wire logic                        lba_mode_i,
  input  wire logic [dvf_pkg::CYL_W-1:0]   cylinder_reg_i,
  input  wire logic [dvf_pkg::HEAD_W-1:0]  head_select_reg_i,
  input  wire logic [dvf_pkg::SECT_W-1:0]  sector_number_reg_i,
  input  wire logic [15:0]                 sector_count_reg_i,
  input  wire logic [dvf_pkg::ADDR_W-1:0]  lba_i,
  // Host data words
  input  wire logic                        data_wr_i,
  input  wire logic [dvf_pkg::DATA_W-1:0]  data_i,
  // Status toward host
  output logic                             bsy_o,
  output logic                             drq_o,
  output logic                             irq_o,
  output logic                             err_o,
  output logic [1:0]                       err_cause_o,
  // Seek mechanics
  input  wire logic                        on_track_i,
  output logic                             seek_req_o,
  input  wire logic                        seek_done_i,
  // Media engine
  output logic                             media_start_o,
  output logic [1:0]                       media_op_o,
  output logic [dvf_pkg::ADDR_W-1:0]       media_addr_o,
  output logic [dvf_pkg::ENT_W-1:0]        fmt_entries_o,
  input  wire logic                        media_done_i,
  input  wire logic                        media_err_i,
  input  wire logic [dvf_pkg::WIDX_W-1:0]  media_rd_addr_i,
  output logic [dvf_pkg::DATA_W-1:0]       media_rd_data_o
);

  dvf_pkg::dvf_core_s r, n;

  logic [dvf_pkg::ADDR_W-1:0] chs_addr;
  dvf_pkg::dvf_cnt_t          cnt28;
  dvf_pkg::dvf_cnt_t          cnt48;
  logic                       fmt_clear;

  dvf_buf_if u_bus ();

  // ----------------------------------------------------------------
  // Start address and sector counts
  // ----------------------------------------------------------------
  // CHS packs cylinder, head, sector; the media engine resolves geometry
  assign chs_addr = {{dvf_pkg::CHS_PAD_W{1'b0}}, cylinder_reg_i, head_select_reg_i, sector_number_reg_i};
  // Zero count means the largest count of each form
  assign cnt28 = (sector_count_reg_i[7:0] == 8'h00) ? dvf_pkg::CNT28_ZERO
               : dvf_pkg::dvf_cnt_t'(sector_count_reg_i[7:0]);
  assign cnt48 = (sector_count_reg_i == 16'h0000) ? dvf_pkg::CNT48_ZERO
               : dvf_pkg::dvf_cnt_t'(sector_count_reg_i);

  // Table tracking restarts on each format command taken in idle, even one aborted in LBA mode
  assign fmt_clear = (r.st == dvf_pkg::ST_IDLE) && cmd_wr_i && (cmd_code_i == dvf_pkg::CMD_FORMAT);

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Commands arriving while busy are ignored; the host must poll BSY
  always_comb begin
    n = r;
    n.irq = 1'b0;
    n.seek_req = 1'b0;
    n.media_start = 1'b0;
    unique case (r.st)
      dvf_pkg::ST_IDLE: begin
        if (cmd_wr_i) begin
          n.err = dvf_pkg::ERR_NONE;
          n.widx = '0;
          n.addr = lba_mode_i ? lba_i : chs_addr;
          if (cmd_code_i == dvf_pkg::CMD_VERIFY) begin
            n.op = dvf_pkg::MOP_READ;
            n.cnt = cnt28;
            n.bsy = 1'b1;
            n.st = dvf_pkg::ST_SEEK;
          end else if (cmd_code_i == dvf_pkg::CMD_VERIFY_EXT) begin
            if (lba_mode_i) begin
              n.op = dvf_pkg::MOP_READ;
              n.cnt = cnt48;
              n.bsy = 1'b1;
              n.st = dvf_pkg::ST_SEEK;
            end else begin
              n.err = dvf_pkg::ERR_ABORT;
              n.irq = 1'b1;
              n.bsy = 1'b0;
              n.drq = 1'b0;
            end
          end else if (cmd_code_i == dvf_pkg::CMD_WRITE_VERIFY) begin
            n.op = dvf_pkg::MOP_WRITE;  // Plain write, no read-back
            n.cnt = cnt28;
            n.drq = 1'b1;
            n.bsy = 1'b0;
            n.st = dvf_pkg::ST_XFER;
          end else if (cmd_code_i == dvf_pkg::CMD_FORMAT) begin
            if (lba_mode_i) begin
              n.err = dvf_pkg::ERR_ABORT;
              n.irq = 1'b1;
              n.bsy = 1'b0;
              n.drq = 1'b0;
            end else begin
              n.op = dvf_pkg::MOP_FORMAT;
              n.cnt = dvf_pkg::CNT_ONE;
              n.drq = 1'b1;
              n.bsy = 1'b0;
              n.st = dvf_pkg::ST_XFER;
            end
          end
        end
      end
      // One sector of host words; format table uses the same path
      dvf_pkg::ST_XFER: begin
        if (data_wr_i) begin
          n.widx = r.widx + 1'b1;
          if (r.widx == dvf_pkg::LAST_WORD) begin
            n.drq = 1'b0;
            n.bsy = 1'b1;
            n.st = dvf_pkg::ST_SEEK;
          end
        end
      end
      // Head position checked per sector; a seek is only issued when needed
      dvf_pkg::ST_SEEK: begin
        if (!r.seeking) begin
          if (on_track_i) begin
            n.media_start = 1'b1;
            n.st = dvf_pkg::ST_MEDIA;
          end else begin
            n.seeking = 1'b1;
            n.seek_req = 1'b1;
          end
        end else if (seek_done_i) begin
          n.seeking = 1'b0;
          n.media_start = 1'b1;
          n.st = dvf_pkg::ST_MEDIA;
        end
      end
      dvf_pkg::ST_MEDIA: begin
        if (media_err_i) begin
          n.err = dvf_pkg::ERR_MEDIA;
          n.irq = 1'b1;
          n.bsy = 1'b0;
          n.drq = 1'b0;
          n.st = dvf_pkg::ST_IDLE;
        end else if (media_done_i) begin
          n.cnt = r.cnt - 1'b1;
          n.addr = r.addr + 1'b1;
          if (r.op == dvf_pkg::MOP_FORMAT || r.cnt == dvf_pkg::CNT_ONE) begin
            n.irq = 1'b1;
            n.bsy = 1'b0;
            n.drq = 1'b0;
            n.st = dvf_pkg::ST_IDLE;
          end else if (r.op == dvf_pkg::MOP_READ) begin
            n.st = dvf_pkg::ST_SEEK;  // Verify stays silent between sectors
          end else begin
            n.drq = 1'b1;
            n.bsy = 1'b0;
            n.irq = 1'b1;
            n.widx = '0;
            n.st = dvf_pkg::ST_XFER;
          end
        end
      end
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= dvf_pkg::CORE_RST;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Buffer and format table
  // ----------------------------------------------------------------
  // Host words only land while DRQ is up, so stray strobes do no harm
  assign u_bus.wr_en   = r.drq && data_wr_i;
  assign u_bus.wr_addr = r.widx;
  assign u_bus.wr_data = data_i;
  assign u_bus.rd_addr = media_rd_addr_i;

  dvf_sector_buf u_buf (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .bus     (u_bus)
  );

  dvf_fmt_parser u_parse (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .clear_i   (fmt_clear),
    .bus       (u_bus),
    .entries_o (fmt_entries_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bsy_o           = r.bsy;
  assign drq_o           = r.drq;
  assign irq_o           = r.irq;
  assign err_cause_o     = r.err;
  assign err_o           = (r.err != dvf_pkg::ERR_NONE);
  assign seek_req_o      = r.seek_req;
  assign media_start_o   = r.media_start;
  assign media_op_o      = r.op;
  assign media_addr_o    = r.addr;  // Format uses the CHS track, interleave one
  assign media_rd_data_o = u_bus.rd_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !ce_i);

  logic idle_cmd;
  assign idle_cmd = (r.st == dvf_pkg::ST_IDLE) && cmd_wr_i;

  property p_verify_no_drq;
    (r.op == dvf_pkg::MOP_READ) && (r.st != dvf_pkg::ST_IDLE) |-> !drq_o && bsy_o;
  endproperty
  a_verify_no_drq: assert property (p_verify_no_drq) else $error("DRQ during verify");

  property p_ext_chs_abort;
    idle_cmd && (cmd_code_i == dvf_pkg::CMD_VERIFY_EXT) && !lba_mode_i
      |=> irq_o && !bsy_o && (err_cause_o == dvf_pkg::ERR_ABORT) && (r.st == dvf_pkg::ST_IDLE);
  endproperty
  a_ext_chs_abort: assert property (p_ext_chs_abort) else $error("48-bit verify not aborted in CHS");

  property p_fmt_lba_abort;
    idle_cmd && (cmd_code_i == dvf_pkg::CMD_FORMAT) && lba_mode_i
      |=> irq_o && !drq_o && (err_cause_o == dvf_pkg::ERR_ABORT);
  endproperty
  a_fmt_lba_abort: assert property (p_fmt_lba_abort) else $error("Format not aborted in LBA");

  property p_take_drq;
    idle_cmd && ((cmd_code_i == dvf_pkg::CMD_WRITE_VERIFY) || (cmd_code_i == dvf_pkg::CMD_FORMAT && !lba_mode_i))
      |=> drq_o && !bsy_o && !irq_o ##1 drq_o;
  endproperty
  a_take_drq: assert property (p_take_drq) else $error("DRQ not raised on data command");

  property p_sector_in;
    r.drq && data_wr_i && (r.widx == dvf_pkg::LAST_WORD) |=> !drq_o && bsy_o && (r.st == dvf_pkg::ST_SEEK);
  endproperty
  a_sector_in: assert property (p_sector_in) else $error("DRQ/BSY wrong after full sector");

  property p_implied_seek;
    (r.st == dvf_pkg::ST_SEEK) && !r.seeking && !on_track_i |=> seek_req_o && !media_start_o;
  endproperty
  a_implied_seek: assert property (p_implied_seek) else $error("No seek while off track");

  property p_media_after_seek;
    (r.st == dvf_pkg::ST_SEEK) && r.seeking && seek_done_i |=> media_start_o ##1 !media_start_o;
  endproperty
  a_media_after_seek: assert property (p_media_after_seek) else $error("Media op not started after seek");

  property p_next_sector;
    (r.st == dvf_pkg::ST_MEDIA) && media_done_i && !media_err_i && (r.op == dvf_pkg::MOP_WRITE)
      && (r.cnt != dvf_pkg::CNT_ONE) |=> drq_o && !bsy_o && irq_o ##1 !irq_o;
  endproperty
  a_next_sector: assert property (p_next_sector) else $error("Next sector not requested");

  property p_error_end;
    (r.st == dvf_pkg::ST_MEDIA) && media_err_i
      |=> irq_o && !bsy_o && !drq_o && (err_cause_o == dvf_pkg::ERR_MEDIA);
  endproperty
  a_error_end: assert property (p_error_end) else $error("Error end not reported");

  property p_verify_quiet;
    (r.st == dvf_pkg::ST_MEDIA) && (r.op == dvf_pkg::MOP_READ) && media_done_i && !media_err_i
      && (r.cnt != dvf_pkg::CNT_ONE) |=> !irq_o && bsy_o;
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("Verify interrupt before completion");

  property p_fmt_done;
    (r.st == dvf_pkg::ST_MEDIA) && (r.op == dvf_pkg::MOP_FORMAT) && media_done_i
      |=> !bsy_o && irq_o && (r.st == dvf_pkg::ST_IDLE);
  endproperty
  a_fmt_done: assert property (p_fmt_done) else $error("Format end not signalled");

  property p_verify_done;
    (r.st == dvf_pkg::ST_MEDIA) && (r.op == dvf_pkg::MOP_READ) && media_done_i && (r.cnt == dvf_pkg::CNT_ONE);
  endproperty
  c_verify_done: cover property (p_verify_done);

  property p_write_more;
    (r.st == dvf_pkg::ST_MEDIA) && (r.op == dvf_pkg::MOP_WRITE) && media_done_i && (r.cnt != dvf_pkg::CNT_ONE);
  endproperty
  c_write_more: cover property (p_write_more);

  property p_fmt_seen;
    (r.st == dvf_pkg::ST_MEDIA) && (r.op == dvf_pkg::MOP_FORMAT) && media_done_i && (fmt_entries_o != '0);
  endproperty
  c_fmt_seen: cover property (p_fmt_seen);

  property p_abort_seen;
    irq_o && (err_cause_o == dvf_pkg::ERR_ABORT);
  endproperty
  c_abort_seen: cover property (p_abort_seen);

endmodule // dvf_core

// ### test/dvf_mech_model.sv
module dvf_mech_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Scenario controls
  input  wire logic       slow_i,
  input  wire logic       fail_i,
  input  wire logic       off_i,
  // Seek and media handshake
  input  wire logic       seek_req_i,
  input  wire logic       media_start_i,
  output logic            on_track_o,
  output logic            seek_done_o,
  output logic            media_done_o,
  output logic            media_err_o,
  output logic [7:0]      rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned wait_r;
  logic        seek_r;
  logic        med_r;

  // One timer serves seek and media; slow answers stretch it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {wait_r, seek_r, med_r, seek_done_o, media_done_o, media_err_o, rd_addr_o} <= '0;
      on_track_o <= 1'b1;
    end else begin
      {seek_done_o, media_done_o, media_err_o} <= 3'h0;
      rd_addr_o <= rd_addr_o + 8'h01; // Sweeps buffer reads all the time
      if (off_i) begin
        on_track_o <= 1'b0;
      end
      if (seek_req_i || media_start_i) begin
        wait_r <= slow_i ? 40 : 3;
        seek_r <= seek_req_i;
        med_r  <= media_start_i;
      end else if (wait_r > 1) begin
        wait_r <= wait_r - 1;
      end else if (wait_r == 1) begin
        wait_r       <= 0;
        seek_done_o  <= seek_r;
        on_track_o   <= on_track_o | seek_r; // Head lands after a seek
        media_done_o <= med_r & ~fail_i;
        media_err_o  <= med_r & fail_i; // Only when the bench asks
      end
    end
  end
endmodule // dvf_mech_model

// ### test/dvf_core_tb_top.sv
module dvf_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock_i, rst_i = 1'b1, cmd_wr_i = 1'b0, lba_mode_i = 1'b0, data_wr_i = 1'b0;
  logic        fail_i = 1'b0, slow_i = 1'b0, off_i = 1'b0;
  logic [7:0]  cmd_code_i = 8'h00, sector_number_reg_i = 8'h00, rd_addr;
  logic [15:0] cylinder_reg_i = 16'h0000, sector_count_reg_i = 16'h0000, data_i = 16'h0000, rd_data;
  logic [3:0]  head_select_reg_i = 4'h0;
  logic [47:0] lba_i = 48'h0, first_addr, media_addr_o;
  logic        bsy_o, drq_o, irq_o, err_o, seek_req_o, media_start_o, on_track, seek_done, m_done, m_err;
  logic [1:0]  err_cause_o, media_op_o, last_op;
  logic [8:0]  fmt_entries_o;
  int          failures = 0, tests_run = 0, cycles = 0, irqs, seeks, starts, drqs, k, e, s;
  integer      seed = 32'hff46;
  logic [7:0]  code, ra_q = 8'h00;
  logic        lb, drq_q = 1'b0;
  logic [15:0] exp_mem [256];

  dvf_core dvf_core_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .cmd_wr_i(cmd_wr_i),
    .cmd_code_i(cmd_code_i), .lba_mode_i(lba_mode_i), .cylinder_reg_i(cylinder_reg_i),
    .head_select_reg_i(head_select_reg_i), .sector_number_reg_i(sector_number_reg_i),
    .sector_count_reg_i(sector_count_reg_i), .lba_i(lba_i), .data_wr_i(data_wr_i), .data_i(data_i),
    .bsy_o(bsy_o), .drq_o(drq_o), .irq_o(irq_o), .err_o(err_o), .err_cause_o(err_cause_o),
    .on_track_i(on_track), .seek_req_o(seek_req_o), .seek_done_i(seek_done), .media_start_o(media_start_o),
    .media_op_o(media_op_o), .media_addr_o(media_addr_o), .fmt_entries_o(fmt_entries_o),
    .media_done_i(m_done), .media_err_i(m_err), .media_rd_addr_i(rd_addr), .media_rd_data_o(rd_data));

  dvf_mech_model dvf_mech_model_inst (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow_i), .fail_i(fail_i),
    .off_i(off_i), .seek_req_i(seek_req_o), .media_start_i(media_start_o), .on_track_o(on_track),
    .seek_done_o(seek_done), .media_done_o(m_done), .media_err_o(m_err), .rd_addr_o(rd_addr));

  // ----------------------------------------------------------------
  // Clock and event monitor
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Counts pulses per command; the ceiling cuts a hung run short
  always @(posedge clock_i) begin
    cycles++;
    irqs  += (irq_o === 1'b1);
    seeks += (seek_req_o === 1'b1);
    drqs  += (drq_o === 1'b1);
    // Buffer read-back, only once no host word can still be landing
    if (!rst_i && !drq_o && !drq_q) chk(rd_data, exp_mem[ra_q]);
    drq_q = drq_o;
    ra_q  = rd_addr;
    if (media_start_o === 1'b1) begin
      if (starts == 0) first_addr = media_addr_o;
      last_op = media_op_o;
      starts++;
    end
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [47:0] exp_addr(input logic lba);
    exp_addr = lba ? lba_i : {20'h00000, cylinder_reg_i, head_select_reg_i, sector_number_reg_i};
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One sector of host words; format entries get a random type byte
  task automatic feed(input int ent);
    chk({bsy_o, drq_o}, 2'b01);
    for (int i = 0; i < 256; i++) begin
      data_wr_i = 1'b1;
      data_i    = (ent == 0) ? 16'($random(seed)) : (i < ent) ? {8'(i + 1), 8'($random(seed))} : 16'h0000;
      exp_mem[i] = data_i;
      @(posedge clock_i);
      #5;
    end
    data_wr_i = 1'b0;
    @(posedge clock_i);
    #5;
    chk({bsy_o, drq_o}, 2'b10);
  endtask

  task automatic run(input logic [7:0] c, input logic lba, input logic [15:0] sc, input int ent,
                     input logic off, input logic [1:0] ecause);
    int n;
    @(posedge clock_i);
    #5;
    {cmd_code_i, lba_mode_i, sector_count_reg_i, off_i, slow_i, cmd_wr_i} = {c, lba, sc, off, 1'($random(seed)), 1'b1};
    lba_i = {20'h00000, 28'($random(seed))};
    {cylinder_reg_i, head_select_reg_i, sector_number_reg_i} = 28'($random(seed));
    {irqs, seeks, starts, drqs} = '0;
    @(posedge clock_i);
    #5;
    {cmd_wr_i, off_i} = 2'b00;
    @(posedge clock_i);
    #5;
    n = 0;
    while ((bsy_o === 1'b1 || drq_o === 1'b1) && n < 9000) begin
      if (drq_o === 1'b1) feed(ent);
      @(posedge clock_i);
      #5;
      n++;
    end
    repeat (2) @(posedge clock_i);
    #5;
    chk({bsy_o, drq_o, err_cause_o, err_o}, {2'b00, ecause, ecause != 2'h0});
    if (starts > 0) chk(first_addr, exp_addr(lba));
  endtask

  task automatic print_verdict();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) exp_mem[i] = 16'h0000;
    repeat (3) @(posedge clock_i);
    #5;
    rst_i = 1'b0;
    // Two-sector write with the head off track; legacy command kept in test
    run(8'h3C, 1'b1, 16'h0002, 0, 1'b1, 2'h0);
    chk(irqs, 2);
    chk(seeks, 1);
    chk(starts, 2);
    chk(last_op, 2'h1);
    // Verify, both codes; first two runs force the CHS and LBA corners of 42h
    for (k = 0; k < 10; k++) begin
      code = (k < 2 || $random(seed) % 2) ? 8'h42 : 8'h40;
      lb   = (k < 2) ? k[0] : 1'($random(seed));
      s    = 1 + k % 3;
      // 28-bit form must ignore the high count byte, so it gets noise there
      run(code, lb, {(code == 8'h40) ? 8'($random(seed)) : 8'h00, 8'(s)}, 0, 1'($random(seed)),
          (code == 8'h42 && !lb) ? 2'h1 : 2'h0);
      chk(drqs, 0);
      chk(irqs, 1);
      chk(starts, (code == 8'h42 && !lb) ? 0 : s);
    end
    // Media failure ends the command with one interrupt
    fail_i = 1'b1;
    run(8'h40, 1'b1, 16'h0001, 0, 1'b0, 2'h2);
    chk(irqs, 1);
    fail_i = 1'b0;
    // Format refused in LBA mode
    run(8'h50, 1'b1, 16'h0001, 5, 1'b0, 2'h1);
    chk(starts, 0);
    chk(irqs, 1);
    // Format off track with a random table length
    e = 1 + ({$random(seed)} % 200);
    run(8'h50, 1'b0, 16'h0001, e, 1'b1, 2'h0);
    chk(fmt_entries_o, e);
    chk(last_op, 2'h2);
    chk(seeks, 1);
    chk(irqs, 1);
    print_verdict();
  end
endmodule // dvf_core_tb_top
